//--- sdwp_defs.svh
// Constants for the write and precharge control logic of the memory device
// Functional notes
// R1: Controller gives bank, column and auto precharge choice with every write.
// R2: First write word is taken with the command, one more each later edge.
// R3: After a fixed burst ends, data lines float and input data is ignored.
// R4: Full page write runs until stopped; column wraps from last to zero.
// R5: A write may follow any write on any bank; its data is its own.
// R6: A read stops the write burst; from that edge no more words are written.
// R7: Controller closes a written row only after write recovery from last word.
// R8: Auto precharge after a write waits one clock plus write recovery.
// R9: At fast clocks controller masks data before and with a truncating close.
// R10: Controller sends nothing to a closing bank until precharge period ends.
// R11: Burst terminate drops its own word; the word before is the last written.
// R12: Write burst mode bit set makes writes single column; reads keep length.
// R13: Close with scope line high closes all banks, low only the selected one.
// R14: Controller opens a row in an idle bank before reading or writing it.
// R15: Scope line high on read or write closes the bank at burst end.
// R16: Single writes with full page length: full page wins, no auto precharge.
// R17: Auto precharge choice holds for its own command only.
// R18: Controller waits the precharge period after an auto precharge command.
// R19: Read to another bank cuts an auto precharge read; close starts then.
// R20: Write to another bank cuts an auto precharge read; close starts then.
// R21: Read to another bank cuts auto precharge write; recovery counts from it.
// R22: Write to another bank cuts auto precharge write; recovery counts from it.
// R23: Write byte mask acts on the same edge as its data word.
// R24: Read byte mask turns output drivers off two clocks after sampling.
// R25: Controller turns least times into whole cycles, rounding up.
// R26: Each bank keeps its own open state and recovery and precharge timers.
`ifndef SDWP_DEFS_SVH
`define SDWP_DEFS_SVH

`define SDWP_BANKS     4
`define SDWP_ADR_MODE  8'h00
`define SDWP_ADR_TIM   8'h04
`define SDWP_ADR_STAT  8'h08
`define SDWP_F_BL      2:0
`define SDWP_F_LAT     5:4
`define SDWP_F_WBM     9
`define SDWP_F_TWR     3:0
`define SDWP_F_TRP     11:8
`define SDWP_F_OPEN    3:0
`define SDWP_F_BUSY    7:4
`define SDWP_F_WACT    8
`define SDWP_F_RACT    9
`define SDWP_F_COL     7:0
`define SDWP_A_SCOPE   10
`define SDWP_BL_FULL   3'h7
`define SDWP_PAGE_LEN  9'h100
`define SDWP_CMD_ACT   3'h3
`define SDWP_CMD_RD    3'h5
`define SDWP_CMD_WR    3'h4
`define SDWP_CMD_PRE   3'h2
`define SDWP_CMD_BST   3'h6
`define SDWP_CLK_NS    40
`define SDWP_TWR_NS    12
`define SDWP_TRP_NS    18
`define SDWP_TWR_CYC   ((`SDWP_TWR_NS + `SDWP_CLK_NS - 1) / `SDWP_CLK_NS)
`define SDWP_TRP_CYC   ((`SDWP_TRP_NS + `SDWP_CLK_NS - 1) / `SDWP_CLK_NS)
`define SDWP_MODE_RST  32'h0000_0020
`define SDWP_MODE_MSK  32'h0000_0237
`define SDWP_TIM_MSK   32'h0000_0f0f
`define SDWP_TIM_RST   {20'h0, 4'(`SDWP_TRP_CYC), 4'h0, 4'(`SDWP_TWR_CYC)}

`endif

//--- sdwp_pkg.sv
// Types shared by the write and precharge control logic
package sdwp_pkg;

	typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_RECOV, BK_PRECH} sdwp_bank_st_t;

	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [11:0] addr;
		logic [1:0]  ba;
		logic [3:0]  dqm;
		logic [31:0] dq;
	} sdwp_pins_t;

	typedef struct packed {
		logic       act;
		logic       ap;
		logic       full;
		logic [1:0] bank;
		logic [7:0] col;
		logic [8:0] left;
	} sdwp_burst_t;

	typedef struct packed {
		sdwp_bank_st_t st;
		logic [3:0]    cnt;
	} sdwp_bank_t;

	typedef struct packed {
		sdwp_pins_t  s1;
		sdwp_pins_t  s2;
		logic [3:0]  dqm_p1;
		sdwp_burst_t wb;
		sdwp_burst_t rb;
		logic [1:0]  rwait;
		logic [31:0] mode;
		logic [31:0] tim;
		logic        ack;
		logic [31:0] dat;
		logic        wr_en;
		logic [1:0]  wr_bank;
		logic [7:0]  wr_col;
		logic [31:0] wr_data;
		logic [3:0]  wr_be;
		logic        rd_en;
		logic [1:0]  rd_bank;
		logic [7:0]  rd_col;
		logic        rd_v1;
		logic [31:0] dq;
		logic [3:0]  dq_oe;
	} sdwp_state_t;

endpackage : sdwp_pkg

//--- sdwp_bank.sv
// Per bank open state with recovery and precharge timers
`timescale 1ns/1ns
module sdwp_bank (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Bank events
	input  wire logic       act_i,
	input  wire logic       pre_i,
	input  wire logic       arm_i,
	// Timing in cycles
	input  wire logic [3:0] wr_cyc_i,
	input  wire logic [3:0] rp_cyc_i,
	// Bank state
	output logic            open_o,
	output logic            busy_o
);
	sdwp_pkg::sdwp_bank_t st_q;
	sdwp_pkg::sdwp_bank_t st_d;

	always_comb begin
		st_d = st_q;
		unique case (st_q.st)
			sdwp_pkg::BK_IDLE: begin
				if (act_i) begin
					st_d.st = sdwp_pkg::BK_OPEN;
				end
			end
			sdwp_pkg::BK_OPEN: begin
				if (arm_i) begin
					st_d.st = sdwp_pkg::BK_RECOV; // R8
					st_d.cnt = wr_cyc_i; // R8
				end
			end
			sdwp_pkg::BK_RECOV: begin
				if (st_q.cnt == 4'h0) begin
					st_d.st = sdwp_pkg::BK_PRECH;
					st_d.cnt = rp_cyc_i;
				end else begin
					st_d.cnt = st_q.cnt - 4'h1;
				end
			end
			sdwp_pkg::BK_PRECH: begin
				if (st_q.cnt == 4'h0) begin
					st_d.st = sdwp_pkg::BK_IDLE;
				end else begin
					st_d.cnt = st_q.cnt - 4'h1;
				end
			end
		endcase
		if (pre_i && st_q.st != sdwp_pkg::BK_IDLE) begin
			st_d.st = sdwp_pkg::BK_PRECH; // R26
			st_d.cnt = rp_cyc_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign open_o = st_q.st == sdwp_pkg::BK_OPEN || st_q.st == sdwp_pkg::BK_RECOV;
	assign busy_o = st_q.st == sdwp_pkg::BK_RECOV || st_q.st == sdwp_pkg::BK_PRECH;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	arm_recov_a: assert property (arm_i && !pre_i && st_q.st == sdwp_pkg::BK_OPEN
		|=> st_q.st == sdwp_pkg::BK_RECOV ##1 st_q.st != sdwp_pkg::BK_IDLE) // R8
		else $error("auto precharge skipped write recovery");
	pre_close_a: assert property (pre_i && st_q.st != sdwp_pkg::BK_IDLE
		|=> st_q.st == sdwp_pkg::BK_PRECH) // R26
		else $error("bank did not start precharge");
endmodule : sdwp_bank

//--- sdwp_ctrl.sv
// Write burst, precharge and auto precharge control with register slave
`timescale 1ns/1ns
`include "sdwp_defs.svh"
module sdwp_ctrl (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic                      wb_ack_o,
	output logic [31:0]               wb_dat_o,
	// Device pins
	input  wire sdwp_pkg::sdwp_pins_t pins_i,
	output logic [31:0]               dq_o,
	output logic [3:0]                dq_oe_o,
	// Array write port
	output logic                      wr_en_o,
	output logic [1:0]                wr_bank_o,
	output logic [7:0]                wr_col_o,
	output logic [31:0]               wr_data_o,
	output logic [3:0]                wr_be_o,
	// Array read port
	output logic                      rd_en_o,
	output logic [1:0]                rd_bank_o,
	output logic [7:0]                rd_col_o,
	input  wire logic [31:0]          rd_data_i
);
	sdwp_pkg::sdwp_state_t st_q;
	sdwp_pkg::sdwp_state_t st_d;
	logic [3:0] act;
	logic [3:0] pre;
	logic [3:0] arm;
	logic [3:0] bk_open;
	logic [3:0] bk_busy;
	logic [2:0] code;
	logic       cmd_v;
	logic       cmd_wr;
	logic       cmd_rd;
	logic       cmd_bst;
	logic       cmd_pre;
	logic       cmd_act;
	logic       full;
	logic       scope;
	logic [8:0] len;
	logic       req;

	function automatic logic [7:0] col_next(input logic [7:0] c);
		return c + 8'h01;
	endfunction : col_next

	function automatic logic [8:0] bl_len(input logic [2:0] c);
		return (c == `SDWP_BL_FULL) ? `SDWP_PAGE_LEN : (9'h001 << c);
	endfunction : bl_len

	function automatic logic [31:0] wmerge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s, input logic [31:0] m);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r & m;
	endfunction : wmerge

	assign code = {st_q.s2.ras_n, st_q.s2.cas_n, st_q.s2.we_n};
	assign cmd_v = !st_q.s2.cs_n;
	assign cmd_wr = cmd_v && code == `SDWP_CMD_WR;
	assign cmd_rd = cmd_v && code == `SDWP_CMD_RD;
	assign cmd_bst = cmd_v && code == `SDWP_CMD_BST;
	assign cmd_pre = cmd_v && code == `SDWP_CMD_PRE;
	assign cmd_act = cmd_v && code == `SDWP_CMD_ACT;
	assign scope = st_q.s2.addr[`SDWP_A_SCOPE];
	assign full = st_q.mode[`SDWP_F_BL] == `SDWP_BL_FULL;
	assign len = bl_len(st_q.mode[`SDWP_F_BL]);
	assign req = wb_cyc_i && wb_stb_i;

	always_comb begin
		st_d = st_q;
		act = 4'h0;
		pre = 4'h0;
		arm = 4'h0;
		// Pin synchroniser
		st_d.s1 = pins_i;
		st_d.s2 = st_q.s1;
		st_d.dqm_p1 = st_q.s2.dqm;
		st_d.wr_en = 1'h0;
		st_d.rd_en = 1'h0;
		// Read data drive, gated by the delayed mask
		st_d.rd_v1 = st_q.rd_en;
		st_d.dq = rd_data_i;
		st_d.dq_oe = {4{st_q.rd_v1}} & ~st_q.dqm_p1; // R24
		// Running write burst
		if (st_q.wb.act) begin
			st_d.wr_en = 1'h1; // R2
			st_d.wr_bank = st_q.wb.bank;
			st_d.wr_col = st_q.wb.col;
			st_d.wr_data = st_q.s2.dq;
			st_d.wr_be = ~st_q.s2.dqm; // R23
			st_d.wb.col = col_next(st_q.wb.col); // R4
			if (!st_q.wb.full) begin
				st_d.wb.left = st_q.wb.left - 9'h001;
				if (st_q.wb.left == 9'h001) begin
					st_d.wb.act = 1'h0; // R3
					arm[st_q.wb.bank] = st_q.wb.ap; // R15
				end
			end
		end
		// Running read burst
		if (st_q.rb.act) begin
			if (st_q.rwait != 2'h0) begin
				st_d.rwait = st_q.rwait - 2'h1;
			end else begin
				st_d.rd_en = 1'h1;
				st_d.rd_bank = st_q.rb.bank;
				st_d.rd_col = st_q.rb.col;
				st_d.rb.col = col_next(st_q.rb.col);
				if (!st_q.rb.full) begin
					st_d.rb.left = st_q.rb.left - 9'h001;
					if (st_q.rb.left == 9'h001) begin
						st_d.rb.act = 1'h0;
						pre[st_q.rb.bank] = st_q.rb.ap; // R15
					end
				end
			end
		end
		// Commands
		if (cmd_wr || cmd_rd) begin
			if (st_q.rb.act && st_q.rb.ap && st_q.rb.bank != st_q.s2.ba) begin
				pre[st_q.rb.bank] = 1'h1; // R19 R20
			end
			if (st_q.wb.act && st_q.wb.ap && st_q.wb.bank != st_q.s2.ba) begin
				arm[st_q.wb.bank] = 1'h1; // R21 R22
			end
			st_d.wb.act = 1'h0; // R6
			st_d.rb.act = 1'h0;
			st_d.wr_en = 1'h0; // R6
			st_d.rd_en = 1'h0;
		end
		if (cmd_wr) begin
			st_d.wr_en = 1'h1; // R2 R5
			st_d.wr_bank = st_q.s2.ba;
			st_d.wr_col = st_q.s2.addr[`SDWP_F_COL];
			st_d.wr_data = st_q.s2.dq;
			st_d.wr_be = ~st_q.s2.dqm; // R23
			st_d.wb.bank = st_q.s2.ba;
			st_d.wb.col = col_next(st_q.s2.addr[`SDWP_F_COL]);
			st_d.wb.full = full; // R16
			st_d.wb.ap = scope && !full; // R15 R16 R17
			if (st_q.mode[`SDWP_F_WBM] && !full) begin
				st_d.wb.act = 1'h0; // R12
				arm[st_q.s2.ba] = scope; // R15
			end else begin
				st_d.wb.left = len - 9'h001;
				st_d.wb.act = full || len != 9'h001;
				arm[st_q.s2.ba] = scope && len == 9'h001;
			end
		end
		if (cmd_rd) begin
			st_d.rb.act = 1'h1; // R12
			st_d.rb.bank = st_q.s2.ba;
			st_d.rb.col = st_q.s2.addr[`SDWP_F_COL];
			st_d.rb.full = full;
			st_d.rb.ap = scope && !full; // R15 R17
			st_d.rb.left = len;
			st_d.rwait = st_q.mode[`SDWP_F_LAT] - 2'h1;
		end
		if (cmd_bst) begin
			st_d.wb.act = 1'h0; // R11
			st_d.rb.act = 1'h0;
			st_d.wr_en = 1'h0; // R11
		end
		if (cmd_pre) begin
			if (scope) begin
				pre = 4'hf; // R13
			end else begin
				pre = 4'h1 << st_q.s2.ba; // R13
			end
			if (scope || st_q.wb.bank == st_q.s2.ba) begin
				st_d.wb.act = 1'h0;
				st_d.wr_en = 1'h0;
			end
			if (scope || st_q.rb.bank == st_q.s2.ba) begin
				st_d.rb.act = 1'h0;
			end
		end
		if (cmd_act) begin
			act = 4'h1 << st_q.s2.ba;
		end
		// Register slave
		st_d.ack = req && !st_q.ack;
		if (req && !st_q.ack) begin
			unique case (wb_adr_i)
				`SDWP_ADR_MODE: st_d.dat = st_q.mode;
				`SDWP_ADR_TIM: st_d.dat = st_q.tim;
				`SDWP_ADR_STAT: begin
					st_d.dat = 32'h0;
					st_d.dat[`SDWP_F_OPEN] = bk_open;
					st_d.dat[`SDWP_F_BUSY] = bk_busy;
					st_d.dat[`SDWP_F_WACT] = st_q.wb.act;
					st_d.dat[`SDWP_F_RACT] = st_q.rb.act;
				end
				default: st_d.dat = 32'h0;
			endcase
		end
		if (req && st_q.ack && wb_we_i) begin
			if (wb_adr_i == `SDWP_ADR_MODE) begin
				st_d.mode = wmerge(st_q.mode, wb_dat_i, wb_sel_i, `SDWP_MODE_MSK);
			end
			if (wb_adr_i == `SDWP_ADR_TIM) begin
				st_d.tim = wmerge(st_q.tim, wb_dat_i, wb_sel_i, `SDWP_TIM_MSK);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.s1.cs_n <= 1'h1;
			st_q.s2.cs_n <= 1'h1;
			st_q.mode <= `SDWP_MODE_RST;
			st_q.tim <= `SDWP_TIM_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Bank trackers
	for (genvar i = 0; i < `SDWP_BANKS; i++) begin : g_bank
		sdwp_bank u_bank (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.act_i    (act[i]),
			.pre_i    (pre[i]),
			.arm_i    (arm[i]),
			.wr_cyc_i (st_q.tim[`SDWP_F_TWR]),
			.rp_cyc_i (st_q.tim[`SDWP_F_TRP]),
			.open_o   (bk_open[i]),
			.busy_o   (bk_busy[i])
		); // R26
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.dat;
	assign dq_o = st_q.dq;
	assign dq_oe_o = st_q.dq_oe;
	assign wr_en_o = st_q.wr_en;
	assign wr_bank_o = st_q.wr_bank;
	assign wr_col_o = st_q.wr_col;
	assign wr_data_o = st_q.wr_data;
	assign wr_be_o = st_q.wr_be;
	assign rd_en_o = st_q.rd_en;
	assign rd_bank_o = st_q.rd_bank;
	assign rd_col_o = st_q.rd_col;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wr_first_a: assert property (cmd_wr |=> st_q.wr_en // R2
		&& st_q.wr_col == $past(st_q.s2.addr[`SDWP_F_COL])
		&& st_q.wr_data == $past(st_q.s2.dq))
		else $error("first write word not taken with command");
	wr_mask_a: assert property (cmd_wr // R23
		|=> st_q.wr_be == ~$past(st_q.s2.dqm))
		else $error("write mask not applied on data edge");
	idle_ignore_a: assert property (!st_q.wb.act && !cmd_wr // R3
		|=> !st_q.wr_en)
		else $error("write outside a burst");
	read_stop_a: assert property (cmd_rd // R6
		|=> !st_q.wr_en && !st_q.wb.act ##1 (!st_q.wr_en || $past(cmd_wr)))
		else $error("write continued after read");
	term_drop_a: assert property (cmd_bst |=> !st_q.wr_en) // R11
		else $error("terminate word was written");
	page_wrap_a: assert property (st_q.wb.act && st_q.wb.full // R4
		&& st_q.wb.col == 8'hff && !cmd_v
		|=> st_q.wr_col == 8'hff && st_q.wb.col == 8'h00 && st_q.wb.act)
		else $error("full page column did not wrap");
	single_wr_a: assert property (cmd_wr && st_q.mode[`SDWP_F_WBM] // R12
		&& !full |=> !st_q.wb.act)
		else $error("single write mode ran a burst");
	ap_scope_a: assert property (cmd_wr && (!scope || full) // R17
		|=> !st_q.wb.ap)
		else $error("auto precharge taken without request");
	pre_scope_a: assert property (cmd_pre // R13
		|-> pre == (scope ? 4'hf : (4'h1 << st_q.s2.ba)))
		else $error("wrong banks precharged");
	cut_rd_a: assert property ((cmd_wr || cmd_rd) && st_q.rb.act // R20
		&& st_q.rb.ap && st_q.rb.bank != st_q.s2.ba |-> pre[st_q.rb.bank])
		else $error("cut read did not start precharge");
	cut_wr_a: assert property ((cmd_wr || cmd_rd) && st_q.wb.act // R22
		&& st_q.wb.ap && st_q.wb.bank != st_q.s2.ba |-> arm[st_q.wb.bank])
		else $error("cut write did not start recovery");
	oe_mask_a: assert property (&$past(st_q.s2.dqm, 2) |-> st_q.dq_oe == 4'h0) // R24
		else $error("output driven while masked");

	burst_run_c: cover property (cmd_wr ##1 st_q.wb.act [*3]);
	cut_ap_c: cover property (cmd_rd && st_q.wb.act && st_q.wb.ap);
	pre_all_c: cover property (cmd_pre && scope);
	read_out_c: cover property (cmd_rd ##[1:8] st_q.dq_oe != 4'h0);
endmodule : sdwp_ctrl

//--- sdwp_mc_model.sv
// Memory controller model that drives command, mask and data pins
`timescale 1ns/1ns
`include "sdwp_defs.svh"
module sdwp_mc_model (
	// Clock
	input  wire logic            clk_i,
	// Device pins
	output sdwp_pkg::sdwp_pins_t pins_o
);
	// Least times as whole cycles, rounded up
	localparam int TWR_CYC = `SDWP_TWR_CYC;
	localparam int TRP_CYC = `SDWP_TRP_CYC;
	// Mask around a truncating close only below 15 ns
	localparam bit MASK_CLOSE = `SDWP_CLK_NS < 15;

	initial pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, 12'h000, 2'h0, 4'h0, 32'h0};

	// One pin cycle; released data lines show the inverse of the last word
	task automatic step(input logic [2:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] m, input logic [31:0] d,
		input logic drv);
		logic [3:0] mk;
		mk = m | {4{MASK_CLOSE && c == `SDWP_CMD_PRE}};
		@(posedge clk_i);
		pins_o <= '{1'b0, c[2], c[1], c[0], a, b, mk,
			drv ? d : ~pins_o.dq};
	endtask : step

	task automatic idle(input int n);
		repeat (n) step(3'h7, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
	endtask : idle

	// Row opened before any access to the bank
	task automatic open_row(input logic [1:0] b);
		step(`SDWP_CMD_ACT, b, 12'h000, 4'h0, 32'h0, 1'b0);
	endtask : open_row

	// Nothing to a closing bank until the precharge period ends
	task automatic close_wait();
		idle(TRP_CYC + 1);
	endtask : close_wait

	// Recovery after the last wanted word before a close; idle words
	// ahead of the close are masked at fast clocks
	task automatic recover();
		repeat (TWR_CYC) step(3'h7, 2'h0, 12'h000, {4{MASK_CLOSE}}, 32'h0,
			1'b0);
	endtask : recover

	// Mask two clocks ahead of a write that follows a read
	task automatic turn();
		repeat (2) step(3'h7, 2'h0, 12'h000, 4'hf, 32'h0, 1'b0);
	endtask : turn
endmodule : sdwp_mc_model

//--- sdwp_ctrl_tb.sv
// Self-checking bench for the write and precharge control block
`timescale 1ns/1ns
`include "sdwp_defs.svh"
module sdwp_ctrl_tb;
	localparam logic [2:0] WR  = `SDWP_CMD_WR;
	localparam logic [2:0] RD  = `SDWP_CMD_RD;
	localparam logic [2:0] BST = `SDWP_CMD_BST;
	localparam logic [2:0] PRE = `SDWP_CMD_PRE;
	localparam logic [2:0] NOP = 3'h7;
	logic                 clk_i     = 1'b0;
	logic                 rst_i     = 1'b1;
	logic                 wb_cyc_i  = 1'b0;
	logic                 wb_stb_i  = 1'b0;
	logic                 wb_we_i   = 1'b0;
	logic [7:0]           wb_adr_i  = 8'h00;
	logic [3:0]           wb_sel_i  = 4'h0;
	logic [31:0]          wb_dat_i  = 32'h0;
	logic [31:0]          rd_data_i = 32'h0;
	logic                 wb_ack_o, wr_en_o, rd_en_o;
	logic [31:0]          wb_dat_o, dq_o, wr_data_o;
	logic [3:0]           dq_oe_o, wr_be_o;
	logic [1:0]           wr_bank_o, rd_bank_o, cb;
	logic [7:0]           wr_col_o, rd_col_o, cc;
	sdwp_pkg::sdwp_pins_t pins;
	logic [63:0]          wq[$], rq[$], oq[$], bq[$];
	int                   errors   = 0;
	int                   compares = 0;
	integer               seed     = 32'he25849de;

	always #20 clk_i = ~clk_i;

	sdwp_mc_model u_sdwp_mc_model (.clk_i(clk_i), .pins_o(pins));

	sdwp_ctrl u_sdwp_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .pins_i(pins), .dq_o(dq_o),
		.dq_oe_o(dq_oe_o), .wr_en_o(wr_en_o), .wr_bank_o(wr_bank_o),
		.wr_col_o(wr_col_o), .wr_data_o(wr_data_o), .wr_be_o(wr_be_o),
		.rd_en_o(rd_en_o), .rd_bank_o(rd_bank_o), .rd_col_o(rd_col_o),
		.rd_data_i(rd_data_i));

	function automatic logic [31:0] pat(input logic [1:0] b,
		input logic [7:0] c);
		return {8'h5a, 6'h00, b, c, c ^ 8'h3c};
	endfunction : pat

	function automatic logic [63:0] take(ref logic [63:0] q[$]);
		if (q.size() == 0)
			return 64'hbad0_bad0_bad0_bad0;
		return q.pop_front();
	endfunction : take

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Array answers the cycle after each read strobe
	always @(posedge clk_i)
		if (rd_en_o === 1'b1)
			rd_data_i <= pat(rd_bank_o, rd_col_o);

	always @(posedge clk_i) begin
		if (wr_en_o === 1'b1)
			check({wr_bank_o, wr_col_o, wr_data_o, wr_be_o}, take(wq));
		if (rd_en_o === 1'b1)
			check({rd_bank_o, rd_col_o}, take(rq));
		if (dq_oe_o !== 4'h0)
			check({dq_oe_o, dq_o}, take(oq));
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, take(bq));
	end

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			errors++;
			conclude();
		end else begin
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask : wb

	task automatic rdreg(input logic [7:0] adr, input logic [31:0] exp);
		bq.push_back({32'h0, exp});
		wb(1'b0, adr, 32'h0);
	endtask : rdreg

	task automatic mode(input logic [2:0] bl, input logic wbm);
		wb(1'b1, `SDWP_ADR_MODE, {22'h0, wbm, 3'h0, 2'h2, 1'b0, bl});
	endtask : mode

	// One data cycle; a kept word is noted as an expected array write
	task automatic put(input logic [2:0] code, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] m, input logic keep);
		logic [31:0] d;
		d = $random(seed);
		if (code == WR) begin
			cb = b;
			cc = a[7:0];
		end
		if (keep)
			wq.push_back({cb, cc, d, ~m});
		cc++;
		u_sdwp_mc_model.step(code, b, a, m, d, 1'b1);
	endtask : put

	task automatic rd(input logic [1:0] b, input logic [7:0] c);
		for (int i = 0; i < 4; i++) begin
			rq.push_back({b, c + 8'(i)});
			oq.push_back({4'hf, pat(b, c + 8'(i))});
		end
		u_sdwp_mc_model.step(RD, b, {4'h0, c}, 4'h0, 32'h0, 1'b0);
	endtask : rd

	task automatic pre(input logic [11:0] a, input logic [31:0] st);
		u_sdwp_mc_model.recover();
		u_sdwp_mc_model.step(PRE, 2'h1, a, 4'h0, 32'h0, 1'b0);
		u_sdwp_mc_model.close_wait();
		// Pin synchroniser delays the close as seen in status
		u_sdwp_mc_model.idle(3);
		rdreg(`SDWP_ADR_STAT, st);
	endtask : pre

	task automatic fin(input string s);
		u_sdwp_mc_model.idle(10);
		$display("test %s done", s);
	endtask : fin

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdreg(`SDWP_ADR_MODE, `SDWP_MODE_RST);
		rdreg(`SDWP_ADR_TIM, `SDWP_TIM_RST);
		wb(1'b1, `SDWP_ADR_STAT, 32'hffff_ffff);
		rdreg(`SDWP_ADR_STAT, 32'h0);
		wb(1'b1, 8'h40, 32'h1234_5678);
		rdreg(8'h40, 32'h0);
		mode(3'h2, 1'b0);
		rdreg(`SDWP_ADR_MODE, 32'h0000_0022);
		for (int b = 0; b < 4; b++)
			u_sdwp_mc_model.open_row(2'(b));
		fin("registers");
		for (int i = 0; i < 6; i++)
			put(i == 0 ? WR : NOP, 2'h0, 12'h010, i == 1 ? 4'h5 : 4'h0,
				i < 4);
		for (int i = 0; i < 6; i++)
			put(i == 0 || i == 2 ? WR : NOP, i < 2 ? 2'h1 : 2'h2,
				i < 2 ? 12'h020 : 12'h030, 4'h0, 1'b1);
		put(WR, 2'h0, 12'h040, 4'h0, 1'b1);
		put(NOP, 2'h0, 12'h000, 4'h0, 1'b1);
		rd(2'h3, 8'h08);
		put(NOP, 2'h0, 12'h000, 4'h0, 1'b0);
		fin("write cut");
		mode(3'h3, 1'b0);
		for (int i = 0; i < 5; i++)
			put(i == 0 ? WR : i == 3 ? BST : NOP, 2'h1, 12'h050, 4'h0,
				i < 3);
		mode(3'h7, 1'b0);
		for (int i = 0; i < 6; i++)
			put(i == 0 ? WR : i == 4 ? BST : NOP, 2'h2, 12'h0fe, 4'h0,
				i < 4);
		fin("terminate");
		mode(3'h2, 1'b1);
		for (int i = 0; i < 3; i++)
			put(i == 0 ? WR : NOP, 2'h3, 12'h060, 4'h0, i == 0);
		rd(2'h3, 8'h60);
		oq[1] = {4'ha, pat(2'h3, 8'h61)};
		u_sdwp_mc_model.idle(3);
		u_sdwp_mc_model.step(NOP, 2'h0, 12'h000, 4'h5, 32'h0,
			1'b0);
		fin("single write");
		u_sdwp_mc_model.turn();
		mode(3'h7, 1'b1);
		for (int i = 0; i < 5; i++)
			put(i == 0 ? WR : i == 3 ? BST : NOP, 2'h0, 12'h470, 4'h0,
				i < 3);
		fin("full page single");
		rdreg(`SDWP_ADR_STAT, 32'h0000_000f);
		mode(3'h1, 1'b0);
		put(WR, 2'h1, 12'h450, 4'h0, 1'b1);
		put(NOP, 2'h0, 12'h000, 4'h0, 1'b1);
		fin("auto close");
		rdreg(`SDWP_ADR_STAT, 32'h0000_000d);
		u_sdwp_mc_model.open_row(2'h1);
		put(WR, 2'h1, 12'h050, 4'h0, 1'b1);
		put(NOP, 2'h0, 12'h000, 4'h0, 1'b1);
		fin("one shot");
		rdreg(`SDWP_ADR_STAT, 32'h0000_000f);
		mode(3'h2, 1'b0);
		for (int i = 0; i < 6; i++)
			put(i == 0 || i == 2 ? WR : NOP, i < 2 ? 2'h2 : 2'h3,
				i < 2 ? 12'h490 : 12'h0a0, 4'h0, 1'b1);
		fin("write cuts auto");
		rdreg(`SDWP_ADR_STAT, 32'h0000_000b);
		u_sdwp_mc_model.open_row(2'h2);
		put(WR, 2'h2, 12'h4b0, 4'h0, 1'b1);
		put(NOP, 2'h0, 12'h000, 4'h0, 1'b1);
		rd(2'h0, 8'h00);
		fin("read cuts auto");
		rdreg(`SDWP_ADR_STAT, 32'h0000_000b);
		rq.push_back({2'h3, 8'hc0});
		oq.push_back({4'hf, pat(2'h3, 8'hc0)});
		u_sdwp_mc_model.step(RD, 2'h3, 12'h4c0, 4'h0, 32'h0,
			1'b0);
		u_sdwp_mc_model.turn();
		for (int i = 0; i < 4; i++)
			put(i == 0 ? WR : NOP, 2'h0, 12'h0c0, 4'h0, 1'b1);
		fin("write cuts auto read");
		rdreg(`SDWP_ADR_STAT, 32'h0000_0003);
		pre(12'h000, 32'h0000_0001);
		pre(12'h400, 32'h0000_0000);
		fin("close");
		check(wq.size() + rq.size() + oq.size() + bq.size(), 64'h0);
		conclude();
	end
endmodule : sdwp_ctrl_tb
